// >>> afecw_pkg.sv
`default_nettype none
package afecw_pkg;
	// ------------------------------------------------------------
	// control word layout
	// ------------------------------------------------------------
	localparam int WORD_W = 16;
	localparam int CW_CTRL_BIT = 15;
	localparam int CW_READ_BIT = 14;
	localparam int CW_DEV_LSB = 11;
	localparam int CW_REG_LSB = 8;
	localparam int NUM_REGS = 8;
	// ------------------------------------------------------------
	// register indices
	// ------------------------------------------------------------
	localparam logic [2:0] REG_MODE = 3'h0;
	localparam logic [2:0] REG_CLOCK = 3'h1;
	localparam logic [2:0] REG_POWER = 3'h2;
	localparam logic [2:0] REG_GAIN12 = 3'h3;
	localparam logic [2:0] REG_GAIN34 = 3'h4;
	localparam logic [2:0] REG_GAIN56 = 3'h5;
	localparam logic [2:0] REG_CHSEL = 3'h6;
	localparam logic [7:0] REG_RESET_VALUE = 8'h00;
	// ------------------------------------------------------------
	// mode register fields
	// ------------------------------------------------------------
	localparam int MODE_DATA_BIT = 0;
	localparam int MODE_MIXED_BIT = 1;
	localparam int MODE_LOOP_BIT = 3;
	localparam int MODE_COUNT_LSB = 4;
	localparam int MODE_SWRESET_BIT = 7;
	// ------------------------------------------------------------
	// clock register fields
	// ------------------------------------------------------------
	localparam int CLK_DEC_LSB = 0;
	localparam int CLK_SCD_LSB = 2;
	localparam int CLK_MCD_LSB = 4;
	localparam int CLK_ECHO_BIT = 7;
	// ------------------------------------------------------------
	// power, gain and channel register fields
	// ------------------------------------------------------------
	localparam int PWR_GLOBAL_BIT = 0;
	localparam int PWR_REF_BIT = 5;
	localparam int PWR_REFERENCE_OUTPUT_PIN_BIT = 6;
	localparam int GAIN_LO_PWR_BIT = 3;
	localparam int GAIN_HI_LSB = 4;
	localparam int GAIN_HI_PWR_BIT = 7;
	localparam int CHSEL_MOD_RESET_BIT = 6;
	localparam int CHSEL_SINGLE_BIT = 7;
	// ------------------------------------------------------------
	// timing: reset lasts four internal master clock cycles
	// ------------------------------------------------------------
	localparam logic [2:0] RESET_MCLK_CYCLES = 3'h4;
	localparam logic [2:0] MCD_MAX_CODE = 3'h4;
	localparam logic [10:0] DEC_BASE_LIMIT = 11'h0ff;
	typedef enum logic [1:0] {AFECW_IDLE, AFECW_SHIFT, AFECW_EXEC, AFECW_RESET} afecw_phase_t;
	typedef struct packed {
		logic serial_clock;
		logic sample_tick;
		logic serial_out;
		logic frame_out;
	} afecw_link_t;
	typedef struct packed {
		logic [1:0] decimation_code;
		logic [1:0] serial_clock_div;
		logic [2:0] master_clock_div;
		logic control_echo_enable;
	} afecw_clkcfg_t;
endpackage : afecw_pkg
`default_nettype wire

// >>> afecw_decoder.sv
// Behaviour
// - bit 15 must be one for a valid control word; else ignored in program mode
// - read bit zero and chain address zero: store data byte in chosen register
// - read bit one, address zero: load register into data field and send word out
// - nonzero chain address is decremented and the word is passed on
// - 3-bit register index picks one of eight registers
// - low byte is write data or read fill, only for words addressed here
// - mode bit 0 selects program (0) or data (1) mode
// - mode bit 1 enables mixed mode
// - mode bit 3 enables serial loop-back
// - mode bits 4-6 hold the cascade device count
// - writing one to mode bit 7 starts a software reset
// - clock bits 0-1 hold decimation rate code
// - clock bits 2-3 hold serial clock divider code
// - clock bits 4-6 hold master clock divider code
// - clock bit 7 enables control echo
// - power bit 0 is global power up
// - power bit 5 powers reference, bit 6 enables reference output
// - gain registers: low nibble and high nibble per channel pair
// - channel power bit one switches the converter channel on
// - channel register bits 0-5 select channels one to six
// - channel register bit 6 resets modulator, bit 7 single-ended input
// - master clock divide 1..5 for codes 0..4, else divide by one
// - serial clock divide 8,4,2,1 for codes 0..3
// - sample rate divide 2048,1024,512,256 for codes 0..3
// - any reset clears all registers, lasting four internal master clock cycles
`timescale 1ns/1ns
`default_nettype none
module afecw_decoder
	import afecw_pkg::*;
(
	// clock and reset
	input wire logic CLOCK,
	input wire logic RSTN,
	// serial link from host or previous device
	input wire logic SERIAL_IN,
	input wire logic FRAME_IN,
	// serial link toward next device or host
	output var logic SERIAL_OUT,
	output var logic FRAME_OUT,
	output var logic SERIAL_CLOCK_OUT,
	output var logic SAMPLE_TICK,
	// configuration outputs
	output var logic DATA_MODE,
	output var logic MIXED_MODE_ENABLE,
	output var logic SERIAL_LOOPBACK_ENABLE,
	output var logic [2:0] CASCADE_COUNT,
	output var afecw_pkg::afecw_clkcfg_t CLOCK_CONFIG,
	output var logic GLOBAL_POWER_UP,
	output var logic REFERENCE_POWER_UP,
	output var logic REFERENCE_OUTPUT_ENABLE,
	output var logic [17:0] CHANNEL_GAIN_CODES,
	output var logic [5:0] CHANNEL_POWER_ON,
	output var logic [5:0] CHANNEL_SELECT,
	output var logic MODULATOR_RESET,
	output var logic SINGLE_ENDED_INPUT_ENABLE,
	output var logic RESET_BUSY
);
	import afecw_pkg::*;

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		afecw_phase_t phase;
		logic [NUM_REGS-1:0][7:0] regs;
		logic [WORD_W-1:0] shift;
		logic [3:0] bit_count;
		logic [WORD_W-1:0] out_shift;
		logic [4:0] out_count;
		logic [2:0] mclk_div_cnt;
		logic mclk_tick;
		logic [2:0] sclk_div_cnt;
		logic sclk_level;
		logic [10:0] dec_cnt;
		logic [2:0] reset_cnt;
		afecw_link_t link;
	} afecw_state_t;

	afecw_state_t state;
	afecw_state_t next_state;

	// ------------------------------------------------------------
	// decoding helpers
	// ------------------------------------------------------------
	function automatic logic [2:0] mclk_limit(input logic [2:0] code);
		// codes past four fall back to divide by one
		if (code > MCD_MAX_CODE) begin
			return 3'h0;
		end
		return code;
	endfunction : mclk_limit

	function automatic logic [2:0] sclk_limit(input logic [1:0] code);
		// half period in internal master ticks minus one: 8,4,2,1 division
		unique case (code)
			2'h0: return 3'h3;
			2'h1: return 3'h1;
			2'h2: return 3'h0;
			2'h3: return 3'h0;
		endcase
	endfunction : sclk_limit

	function automatic logic [10:0] dec_limit(input logic [1:0] code);
		return 11'((DEC_BASE_LIMIT + 11'h1) << (2'h3 - code)) - 11'h1;
	endfunction : dec_limit

	logic [7:0] mode_reg;
	logic [7:0] clk_reg;
	logic shift_edge;
	logic [WORD_W-1:0] word;
	logic word_done;
	logic accepting;

	assign mode_reg = state.regs[REG_MODE];
	assign clk_reg = state.regs[REG_CLOCK];

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		next_state = state;
		next_state.mclk_tick = 1'b0;
		next_state.link.sample_tick = 1'b0;
		shift_edge = 1'b0;
		word = {state.shift[WORD_W-2:0], SERIAL_IN};
		word_done = 1'b0;
		// data mode without mixed mode ignores all input words
		accepting = !mode_reg[MODE_DATA_BIT] || mode_reg[MODE_MIXED_BIT];

		// internal master clock from the input clock
		if (state.mclk_div_cnt >= mclk_limit(clk_reg[CLK_MCD_LSB +: 3])) begin
			next_state.mclk_div_cnt = 3'h0;
			next_state.mclk_tick = 1'b1;
		end else begin
			next_state.mclk_div_cnt = state.mclk_div_cnt + 3'h1;
		end

		// serial clock and sample tick run on internal master ticks
		if (state.mclk_tick) begin
			if (clk_reg[CLK_SCD_LSB +: 2] == 2'h3) begin
				next_state.sclk_level = 1'b1;
				shift_edge = 1'b1;
			end else if (state.sclk_div_cnt >= sclk_limit(clk_reg[CLK_SCD_LSB +: 2])) begin
				next_state.sclk_div_cnt = 3'h0;
				next_state.sclk_level = !state.sclk_level;
				shift_edge = state.sclk_level;
			end else begin
				next_state.sclk_div_cnt = state.sclk_div_cnt + 3'h1;
			end
			if (state.dec_cnt >= dec_limit(clk_reg[CLK_DEC_LSB +: 2])) begin
				next_state.dec_cnt = 11'h0;
				next_state.link.sample_tick = 1'b1;
			end else begin
				next_state.dec_cnt = state.dec_cnt + 11'h1;
			end
		end
		next_state.link.serial_clock = state.sclk_level;

		unique case (state.phase)
			AFECW_RESET: begin
				// registers stay cleared for four internal master cycles
				next_state.regs = '0;
				if (state.mclk_tick) begin
					if (state.reset_cnt == RESET_MCLK_CYCLES - 3'h1) begin
						next_state.phase = AFECW_IDLE;
						next_state.reset_cnt = 3'h0;
					end else begin
						next_state.reset_cnt = state.reset_cnt + 3'h1;
					end
				end
			end
			AFECW_IDLE, AFECW_SHIFT: begin
				if (shift_edge) begin
					// loop-back returns input bits straight to the output
					if (mode_reg[MODE_LOOP_BIT]) begin
						next_state.link.serial_out = SERIAL_IN;
						next_state.link.frame_out = FRAME_IN;
					end else if (state.out_count != 5'h0) begin
						next_state.link.serial_out = state.out_shift[WORD_W-1];
						next_state.out_shift = {state.out_shift[WORD_W-2:0], 1'b0};
						next_state.out_count = state.out_count - 5'h1;
						next_state.link.frame_out = 1'b0;
					end else begin
						next_state.link.serial_out = 1'b0;
						next_state.link.frame_out = 1'b0;
					end
					if (state.phase == AFECW_IDLE && FRAME_IN) begin
						next_state.shift = word;
						next_state.bit_count = 4'h1;
						next_state.phase = AFECW_SHIFT;
					end else if (state.phase == AFECW_SHIFT) begin
						next_state.shift = word;
						next_state.bit_count = state.bit_count + 4'h1;
						if (state.bit_count == 4'hf) begin
							next_state.phase = AFECW_EXEC;
							word_done = 1'b1;
						end
					end
				end
			end
			AFECW_EXEC: begin
				next_state.phase = AFECW_IDLE;
				// words without the control flag are dropped
				if (accepting && state.shift[CW_CTRL_BIT]) begin
					if (state.shift[CW_DEV_LSB +: 3] != 3'h0) begin
						// not ours: pass on with address one lower
						next_state.out_shift = state.shift;
						next_state.out_shift[CW_DEV_LSB +: 3] = state.shift[CW_DEV_LSB +: 3] - 3'h1;
						next_state.out_count = 5'h10;
						next_state.link.frame_out = 1'b1;
					end else if (state.shift[CW_READ_BIT]) begin
						next_state.out_shift = state.shift;
						next_state.out_shift[7:0] = state.regs[state.shift[CW_REG_LSB +: 3]];
						next_state.out_count = 5'h10;
						next_state.link.frame_out = 1'b1;
					end else begin
						next_state.regs[state.shift[CW_REG_LSB +: 3]] = state.shift[7:0];
						if (state.shift[CW_REG_LSB +: 3] == REG_MODE
							&& state.shift[MODE_SWRESET_BIT]) begin
							next_state.phase = AFECW_RESET;
							next_state.regs = '0;
						end else if (clk_reg[CLK_ECHO_BIT]) begin
							// echo the accepted write back out
							next_state.out_shift = state.shift;
							next_state.out_count = 5'h10;
							next_state.link.frame_out = 1'b1;
						end
					end
				end
			end
		endcase
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			state <= '0;
			state.phase <= AFECW_RESET;
		end else begin
			state <= next_state;
		end
	end

	// ------------------------------------------------------------
	// outputs, all registered
	// ------------------------------------------------------------
	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			SERIAL_OUT <= 1'b0;
			FRAME_OUT <= 1'b0;
			SERIAL_CLOCK_OUT <= 1'b0;
			SAMPLE_TICK <= 1'b0;
			DATA_MODE <= 1'b0;
			MIXED_MODE_ENABLE <= 1'b0;
			SERIAL_LOOPBACK_ENABLE <= 1'b0;
			CASCADE_COUNT <= 3'h0;
			CLOCK_CONFIG <= '0;
			GLOBAL_POWER_UP <= 1'b0;
			REFERENCE_POWER_UP <= 1'b0;
			REFERENCE_OUTPUT_ENABLE <= 1'b0;
			// gain and channel power reset in g_gain, one driver each
			CHANNEL_SELECT <= '0;
			MODULATOR_RESET <= 1'b0;
			SINGLE_ENDED_INPUT_ENABLE <= 1'b0;
			RESET_BUSY <= 1'b1;
		end else begin
			SERIAL_OUT <= next_state.link.serial_out;
			FRAME_OUT <= next_state.link.frame_out;
			SERIAL_CLOCK_OUT <= next_state.link.serial_clock;
			SAMPLE_TICK <= next_state.link.sample_tick;
			DATA_MODE <= next_state.regs[REG_MODE][MODE_DATA_BIT];
			MIXED_MODE_ENABLE <= next_state.regs[REG_MODE][MODE_MIXED_BIT];
			SERIAL_LOOPBACK_ENABLE <= next_state.regs[REG_MODE][MODE_LOOP_BIT];
			CASCADE_COUNT <= next_state.regs[REG_MODE][MODE_COUNT_LSB +: 3];
			CLOCK_CONFIG.decimation_code <= next_state.regs[REG_CLOCK][CLK_DEC_LSB +: 2];
			CLOCK_CONFIG.serial_clock_div <= next_state.regs[REG_CLOCK][CLK_SCD_LSB +: 2];
			CLOCK_CONFIG.master_clock_div <= next_state.regs[REG_CLOCK][CLK_MCD_LSB +: 3];
			CLOCK_CONFIG.control_echo_enable <= next_state.regs[REG_CLOCK][CLK_ECHO_BIT];
			GLOBAL_POWER_UP <= next_state.regs[REG_POWER][PWR_GLOBAL_BIT];
			REFERENCE_POWER_UP <= next_state.regs[REG_POWER][PWR_REF_BIT];
			REFERENCE_OUTPUT_ENABLE <= next_state.regs[REG_POWER][PWR_REFERENCE_OUTPUT_PIN_BIT];
			CHANNEL_SELECT <= next_state.regs[REG_CHSEL][5:0];
			MODULATOR_RESET <= next_state.regs[REG_CHSEL][CHSEL_MOD_RESET_BIT];
			SINGLE_ENDED_INPUT_ENABLE <= next_state.regs[REG_CHSEL][CHSEL_SINGLE_BIT];
			RESET_BUSY <= next_state.phase == AFECW_RESET;
		end
	end

	// gain registers repeat one layout per channel pair
	for (genvar g = 0; g < 3; g++) begin : g_gain
		always_ff @(posedge CLOCK or negedge RSTN) begin
			if (!RSTN) begin
				CHANNEL_GAIN_CODES[6*g +: 6] <= 6'h00;
				CHANNEL_POWER_ON[2*g +: 2] <= 2'h0;
			end else begin
				CHANNEL_GAIN_CODES[6*g +: 3] <= next_state.regs[REG_GAIN12 + 3'(g)][2:0];
				CHANNEL_GAIN_CODES[6*g+3 +: 3] <= next_state.regs[REG_GAIN12 + 3'(g)][6:4];
				CHANNEL_POWER_ON[2*g] <= next_state.regs[REG_GAIN12 + 3'(g)][GAIN_LO_PWR_BIT];
				CHANNEL_POWER_ON[2*g+1] <= next_state.regs[REG_GAIN12 + 3'(g)][GAIN_HI_PWR_BIT];
			end
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	logic exec_ok;
	assign exec_ok = state.phase == AFECW_EXEC && accepting && state.shift[CW_CTRL_BIT];

	property p_write_stores;
		@(posedge CLOCK) disable iff (!RSTN)
		exec_ok && state.shift[CW_DEV_LSB +: 3] == 3'h0 && !state.shift[CW_READ_BIT]
			&& !(state.shift[CW_REG_LSB +: 3] == REG_MODE && state.shift[MODE_SWRESET_BIT])
		|=> state.regs[$past(state.shift[CW_REG_LSB +: 3])] == $past(state.shift[7:0]);
	endproperty
	a_write_stores: assert property (p_write_stores) else $error("write not stored");

	property p_read_fill;
		@(posedge CLOCK) disable iff (!RSTN)
		exec_ok && state.shift[CW_DEV_LSB +: 3] == 3'h0 && state.shift[CW_READ_BIT]
		|=> state.out_shift[7:0] == state.regs[$past(state.shift[CW_REG_LSB +: 3])]
			&& state.out_count == 5'h10;
	endproperty
	a_read_fill: assert property (p_read_fill) else $error("read not loaded");

	property p_forward_dec;
		@(posedge CLOCK) disable iff (!RSTN)
		exec_ok && state.shift[CW_DEV_LSB +: 3] != 3'h0
		|=> state.out_shift[CW_DEV_LSB +: 3] == $past(state.shift[CW_DEV_LSB +: 3]) - 3'h1;
	endproperty
	a_forward_dec: assert property (p_forward_dec) else $error("address not decremented");

	property p_invalid_ignored;
		@(posedge CLOCK) disable iff (!RSTN)
		state.phase == AFECW_EXEC && !state.shift[CW_CTRL_BIT] |=> $stable(state.regs);
	endproperty
	a_invalid_ignored: assert property (p_invalid_ignored) else $error("invalid word acted on");

	property p_data_mode_locked;
		@(posedge CLOCK) disable iff (!RSTN)
		state.phase == AFECW_EXEC && mode_reg[MODE_DATA_BIT] && !mode_reg[MODE_MIXED_BIT]
		|=> $stable(state.regs);
	endproperty
	a_data_mode_locked: assert property (p_data_mode_locked) else $error("data mode write");

	property p_swreset;
		@(posedge CLOCK) disable iff (!RSTN)
		exec_ok && state.shift[CW_DEV_LSB +: 3] == 3'h0 && !state.shift[CW_READ_BIT]
			&& state.shift[CW_REG_LSB +: 3] == REG_MODE && state.shift[MODE_SWRESET_BIT]
		|=> state.phase == AFECW_RESET && state.regs == '0;
	endproperty
	a_swreset: assert property (p_swreset) else $error("soft reset missed");

	property p_reset_clear;
		@(posedge CLOCK) disable iff (!RSTN)
		state.phase == AFECW_RESET |-> state.regs == '0;
	endproperty
	a_reset_clear: assert property (p_reset_clear) else $error("regs not clear in reset");

	property p_mode_out;
		@(posedge CLOCK) disable iff (!RSTN)
		##1 DATA_MODE == mode_reg[MODE_DATA_BIT] && CASCADE_COUNT == mode_reg[6:4];
	endproperty
	a_mode_out: assert property (p_mode_out) else $error("mode outputs wrong");

	property p_mclk_div1;
		@(posedge CLOCK) disable iff (!RSTN)
		clk_reg[CLK_MCD_LSB +: 3] > MCD_MAX_CODE && $stable(clk_reg) |=> state.mclk_tick;
	endproperty
	a_mclk_div1: assert property (p_mclk_div1) else $error("master divider fallback");

	c_write: cover property (@(posedge CLOCK) disable iff (!RSTN) exec_ok && !state.shift[CW_READ_BIT]);
	c_read: cover property (@(posedge CLOCK) disable iff (!RSTN) exec_ok && state.shift[CW_READ_BIT]);
	c_reset_done: cover property (@(posedge CLOCK) disable iff (!RSTN)
		state.phase == AFECW_RESET ##1 state.phase == AFECW_IDLE);
endmodule : afecw_decoder
`default_nettype wire

// >>> afecw_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module afecw_host_model (
	// clock and device link
	input wire logic clock,
	input wire logic sclk,
	input wire logic sdo,
	input wire logic fso,
	// host link toward the device
	output var logic sdi,
	output var logic fsi
);
	logic sq;
	logic tx_busy;
	logic [15:0] rx;
	logic [15:0] reply;
	int nrep;
	initial begin
		sdi = 1'b0;
		fsi = 1'b0;
		tx_busy = 1'b0;
		nrep = 0;
	end
	// released line keeps no stale value: toggle once per period
	always @(negedge clock) begin
		sq <= sclk;
		if (!tx_busy && sclk && !sq)
			sdi <= !sdi;
	end
	task automatic edge_wait(input logic lvl);
		do
			@(negedge clock);
		while (!(sclk === lvl && sq === !lvl));
	endtask : edge_wait
	// change on the rising edge, settled at the device's falling edge
	task automatic send(input logic [15:0] w);
		tx_busy = 1'b1;
		for (int i = 15; i >= 0; i--) begin
			edge_wait(1'b1);
			fsi <= (i == 15);
			sdi <= w[i];
		end
		edge_wait(1'b1);
		fsi <= 1'b0;
		sdi <= !w[0];
		@(negedge clock);
		tx_busy = 1'b0;
	endtask : send
	// bit 15 leads on the falling edge after the frame pulse
	initial forever begin
		@(negedge clock);
		if (fso === 1'b1) begin
			edge_wait(1'b0);
			for (int i = 0; i < 16; i++) begin
				edge_wait(1'b1);
				rx = {rx[14:0], sdo};
			end
			reply = rx;
			nrep++;
		end
	end
endmodule : afecw_host_model
`default_nettype wire

// >>> tb_afe_serial_control_word_decoder.sv
`timescale 1ns/1ns
`default_nettype none
module tb_afe_serial_control_word_decoder;
	import afecw_pkg::*;
	logic clock = 1'b0;
	logic rstn = 1'b0;
	logic serial_in, frame_in, serial_out, frame_out, sclk_out, sample_tick, busy;
	logic data_mode, mixed, loopback, global_power_up, refpu, reference_output_pin, modrst, single;
	logic [2:0] count;
	afecw_clkcfg_t clkcfg;
	logic [17:0] gains;
	logic [5:0] pwr_on, chsel;
	logic [1:0] pq;
	int fails = 0;
	int samples_checked = 0;
	localparam logic [7:0] vals [8] = '{8'h72, 8'h71, 8'h61, 8'ha5, 8'h3e, 8'hc7, 8'he9, 8'h5a};
	wire logic [48:0] cfg = {data_mode, mixed, loopback, count, clkcfg, global_power_up, refpu, reference_output_pin,
		gains, pwr_on, chsel, modrst, single};
	always #25 clock = ~clock;
	always @(negedge clock) pq <= {sample_tick, sclk_out};
	afecw_decoder u_dut (.CLOCK(clock), .RSTN(rstn), .SERIAL_IN(serial_in), .FRAME_IN(frame_in),
		.SERIAL_OUT(serial_out), .FRAME_OUT(frame_out), .SERIAL_CLOCK_OUT(sclk_out),
		.SAMPLE_TICK(sample_tick), .DATA_MODE(data_mode), .MIXED_MODE_ENABLE(mixed),
		.SERIAL_LOOPBACK_ENABLE(loopback), .CASCADE_COUNT(count), .CLOCK_CONFIG(clkcfg),
		.GLOBAL_POWER_UP(global_power_up), .REFERENCE_POWER_UP(refpu), .REFERENCE_OUTPUT_ENABLE(reference_output_pin),
		.CHANNEL_GAIN_CODES(gains), .CHANNEL_POWER_ON(pwr_on), .CHANNEL_SELECT(chsel),
		.MODULATOR_RESET(modrst), .SINGLE_ENDED_INPUT_ENABLE(single), .RESET_BUSY(busy));
	afecw_host_model u_host (.clock(clock), .sclk(sclk_out), .sdo(serial_out), .fso(frame_out),
		.sdi(serial_in), .fsi(frame_in));
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic chk(input logic [48:0] got, input logic [48:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic end_sim;
		if (fails == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : end_sim
	function automatic logic [15:0] cw(input logic r, input logic [2:0] dev,
		input logic [2:0] idx, input logic [7:0] d);
		return {1'b1, r, dev, idx, d};
	endfunction : cw
	function automatic logic rise(input int sel);
		return sel ? (sample_tick && !pq[1]) : (sclk_out && !pq[0]);
	endfunction : rise
	// a write must stay silent, so every word waits out a full reply slot
	task automatic xfer(input logic [15:0] w, input logic want, input logic [15:0] exp);
		int n;
		int k;
		n = u_host.nrep;
		k = 0;
		u_host.send(w);
		while (u_host.nrep == n && k < 300) begin
			@(negedge clock);
			k++;
		end
		chk(49'(u_host.nrep != n), 49'(want));
		if (want)
			chk(49'(u_host.reply), 49'(exp));
	endtask : xfer
	task automatic per(input int sel, input int exp);
		int n;
		n = 0;
		do
			@(negedge clock);
		while (!rise(sel));
		do begin
			@(negedge clock);
			n++;
		end while (!rise(sel) && n < 5000);
		chk(49'(n), 49'(exp));
	endtask : per
	task automatic wait_busy(input logic lvl, output int n);
		n = 0;
		while (busy !== lvl && n < 300) begin
			@(negedge clock);
			n++;
		end
	endtask : wait_busy
	task automatic hw_reset;
		int n;
		rstn = 1'b0;
		repeat (6) @(negedge clock);
		chk(cfg, 49'h0);
		chk(49'(busy), 49'h1);
		rstn = 1'b1;
		wait_busy(1'b0, n);
		chk(49'(n >= 4 && n <= 5), 49'h1);
	endtask : hw_reset
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_fields;
		for (int i = 0; i < 8; i++)
			xfer(cw(1'b0, 3'h0, 3'(i), vals[i]), 1'b0, 16'h0000);
		chk(49'({count, loopback, mixed, data_mode}), 49'h3a);
		chk(49'(clkcfg), 49'h4e);
		chk(49'({global_power_up, refpu, reference_output_pin}), 49'h7);
		chk(49'(gains), 49'({3'h4, 3'h7, 3'h3, 3'h6, 3'h2, 3'h5}));
		chk(49'(pwr_on), 49'h26);
		chk(49'({single, modrst, chsel}), 49'he9);
		for (int i = 0; i < 8; i++)
			xfer(cw(1'b1, 3'h0, 3'(i), 8'h00), 1'b1, cw(1'b1, 3'h0, 3'(i), vals[i]));
		per(0, 8);
		per(1, 1024);
	endtask : t_fields
	task automatic t_chain;
		xfer(cw(1'b0, 3'h7, REG_POWER, 8'h00), 1'b1, cw(1'b0, 3'h6, REG_POWER, 8'h00));
		xfer(cw(1'b1, 3'h1, REG_CLOCK, 8'h3c), 1'b1, cw(1'b1, 3'h0, REG_CLOCK, 8'h3c));
		xfer(cw(1'b0, 3'h0, REG_POWER, 8'h00) & 16'h7fff, 1'b0, 16'h0000);
		chk(49'(global_power_up), 49'h1);
	endtask : t_chain
	// echo follows the enable already stored, so the enabling write stays silent
	task automatic t_echo;
		xfer(cw(1'b0, 3'h0, REG_CLOCK, 8'hf0), 1'b0, 16'h0000);
		chk(49'(clkcfg), 49'h0f);
		xfer(cw(1'b0, 3'h0, REG_CLOCK, 8'ha4), 1'b1, cw(1'b0, 3'h0, REG_CLOCK, 8'ha4));
		per(0, 12);
	endtask : t_echo
	task automatic t_swreset;
		int n;
		fork
			u_host.send(cw(1'b0, 3'h0, REG_MODE, 8'h80));
			begin
				wait_busy(1'b1, n);
				wait_busy(1'b0, n);
			end
		join
		chk(49'(n >= 4 && n <= 5), 49'h1);
		chk(cfg, 49'h0);
		per(0, 8);
		per(1, 2048);
	endtask : t_swreset
	// pure data mode cannot be left without a pin reset
	task automatic t_modes;
		xfer(cw(1'b0, 3'h0, REG_MODE, 8'h03), 1'b0, 16'h0000);
		chk(49'({mixed, data_mode}), 49'h3);
		xfer(cw(1'b0, 3'h0, REG_POWER, 8'h40), 1'b0, 16'h0000);
		xfer(cw(1'b0, 3'h0, REG_POWER, 8'h20) & 16'h7fff, 1'b0, 16'h0000);
		xfer(cw(1'b0, 3'h0, REG_MODE, 8'h01), 1'b0, 16'h0000);
		chk(49'({mixed, data_mode}), 49'h1);
		xfer(cw(1'b0, 3'h0, REG_POWER, 8'h01), 1'b0, 16'h0000);
		xfer(cw(1'b1, 3'h0, REG_POWER, 8'h00), 1'b0, 16'h0000);
		chk(49'({global_power_up, refpu, reference_output_pin}), 49'h1);
		hw_reset();
	endtask : t_modes
	task automatic t_loop;
		xfer(cw(1'b0, 3'h0, REG_MODE, 8'h08), 1'b0, 16'h0000);
		chk(49'(loopback), 49'h1);
		xfer(16'h1234, 1'b1, 16'h1234);
		hw_reset();
	endtask : t_loop
	initial begin
		hw_reset();
		t_fields();
		t_chain();
		t_echo();
		t_swreset();
		t_modes();
		t_loop();
		end_sim();
	end
	// about 17k cycles expected; limit set well beyond
	initial begin
		#4_000_000;
		fails++;
		end_sim();
	end
endmodule : tb_afe_serial_control_word_decoder
`default_nettype wire
